// ==== rtl/vrsr_pkg.sv ====
/*
 * vrsr_pkg: constants, modes and state layout for the voltage reference
 * selection register bank.
 * assumes: word index addressing, byte address equals index times four.
 */
package vrsr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // word indices of the register map
    localparam logic [5:0] IDX_VOLT_KNOB = 6'h20;
    localparam logic [5:0] IDX_STABILITY_KNOB = 6'h21;
    localparam logic [5:0] IDX_FREQ_KNOB = 6'h22;
    localparam logic [5:0] IDX_CURR_KNOB = 6'h23;
    localparam logic [5:0] IDX_REG_VOLT = 6'h24;
    localparam logic [5:0] IDX_FREQ = 6'h25;
    localparam logic [5:0] IDX_ALARMS = 6'h26;
    localparam logic [5:0] IDX_ACT_CFG = 6'h27;
    localparam logic [5:0] IDX_COMMAND = 6'h28;
    localparam logic [5:0] IDX_EXT_IN = 6'h29;
    localparam logic [5:0] IDX_NOM_SET = 6'h2a;
    localparam logic [5:0] IDX_EFF_SET = 6'h2b;
    localparam logic [5:0] IDX_MEAS_VOLT = 6'h2c;
    localparam logic [5:0] IDX_TEMP = 6'h2d;
    localparam logic [5:0] IDX_VOL_REF = 6'h31;
    localparam logic [5:0] IDX_KP = 6'h35;
    localparam logic [5:0] IDX_KI = 6'h36;
    localparam logic [5:0] IDX_OVX_THR = 6'h37;
    localparam logic [5:0] IDX_CONFIG = 6'h38;
    localparam logic [5:0] IDX_NV_REF = 6'h39;
    localparam logic [5:0] IDX_RANGE = 6'h3a;

    // configuration word fields and reset values
    localparam int CFG_REF_SRC_BIT = 7;
    localparam int CFG_EXT_EN_BIT = 12;
    localparam logic [15:0] CFG_RESET = 16'h1f1d;
    localparam logic [15:0] NV_REF_RESET = 16'h0000;
    localparam logic [15:0] VOL_REF_RESET = 16'h0000;
    localparam logic [7:0] RANGE_RESET = 8'h0e;
    localparam logic [7:0] RANGE_MAX = 8'h64;

    // value ranges
    localparam logic [15:0] VOLT_MAX = 16'h0c80;
    localparam logic [15:0] FREQ_MAX = 16'h0384;
    localparam logic [15:0] FULL_MAX = 16'h7fff;
    localparam logic [15:0] EXT_LIMIT = 16'h7fff;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_ANALOG,
        MODE_ANALOG_SAT,
        MODE_NV_PARAM,
        MODE_RAM_LOC
    } vrsr_mode_t;

    typedef struct packed {
        logic aw_have;
        logic [5:0] aw_idx;
        logic w_have;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [15:0] rdata;
        logic [1:0] rresp;
        logic [15:0] cfg;
        logic [15:0] nv_ref;
        logic [7:0] range_pct;
        logic [15:0] vol_ref;
        logic [15:0] vref_out;
        logic saturated;
        logic [7:0] variation;
        vrsr_mode_t mode;
        logic open_s1;
        logic open_s2;
    } vrsr_state_t;

endpackage

// ==== rtl/vrsr_top.sv ====
/*
 * vrsr_top: AXI4-Lite register bank choosing the output voltage reference
 * from analogue input, stored parameter or volatile RAM location.
 * assumes: regulator core supplies measurements on aclk; the analogue link
 * open detector is an asynchronous pin.
 */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - bit 7 saturates analogue input at limit
// - with bit 7 set, open analogue link drives maximum range variation
// - ram bit clear uses stored reference parameter
// - volatile location follows stored parameter in stored mode only
// - volatile writes ignored in stored mode
// - ram bit set uses volatile location
// - volatile location lost on shutdown
// - location 36 regulated voltage, 0 to 3200
// - location 37 frequency, 0 to 900
// - location 41 external input, 0 to 32767
// - location 43 effective setpoint, 42 nominal
// - location 45 winding temperature estimate
// - location 49 effective only digital RAM mode
// - location 53 proportional gain mantissa
// - location 54 integral gain mantissa
// - location 55 overexcitation threshold
module vrsr_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] voltage_knob_in,
    input wire logic [15:0] stability_adjust_knob_in,
    input wire logic [15:0] frequency_knob_in,
    input wire logic [15:0] current_adjust_knob_in,
    input wire logic [15:0] regulated_voltage_in,
    input wire logic [15:0] frequency_in,
    input wire logic [15:0] active_alarms_in,
    input wire logic [15:0] external_input_in,
    input wire logic [15:0] nominal_setpoint_in,
    input wire logic [15:0] effective_setpoint_in,
    input wire logic [15:0] measured_voltage_in,
    input wire logic [15:0] winding_temperature_in,
    input wire logic [15:0] proportional_gain_in,
    input wire logic [15:0] integral_gain_in,
    input wire logic [15:0] overexcitation_threshold_in,
    input wire logic ext_link_open,
    output logic [15:0] voltage_reference,
    output logic [7:0] remote_variation_pct,
    output logic output_saturated,
    output vrsr_pkg::vrsr_mode_t reference_mode
);

    vrsr_pkg::vrsr_state_t st_q;
    vrsr_pkg::vrsr_state_t st_d;

    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic ext_en;
    logic ref_src;
    logic [5:0] wr_idx;
    logic [15:0] wr_data;
    logic [1:0] wr_strb;
    logic [15:0] rd_val;
    logic rd_ok;

    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] strb);
        merge = {strb[1] ? nw[15:8] : old[15:8],
                 strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    assign s_axi_awready = !st_q.aw_have && !st_q.bvalid;
    assign s_axi_wready = !st_q.w_have && !st_q.bvalid;
    assign s_axi_arready = !st_q.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rresp = st_q.rresp;
    assign s_axi_rdata = {16'h0000, st_q.rdata};

    assign voltage_reference = st_q.vref_out;
    assign remote_variation_pct = st_q.variation;
    assign output_saturated = st_q.saturated;
    assign reference_mode = st_q.mode;

    assign ext_en = st_q.cfg[vrsr_pkg::CFG_EXT_EN_BIT];
    assign ref_src = st_q.cfg[vrsr_pkg::CFG_REF_SRC_BIT];

    // write channel pieces may arrive in either order
    assign wr_idx = st_q.aw_have ? st_q.aw_idx : s_axi_awaddr[7:2];
    assign wr_data = st_q.w_have ? st_q.w_data : s_axi_wdata[15:0];
    assign wr_strb = st_q.w_have ? st_q.w_strb : s_axi_wstrb[1:0];

    // read decode; measured values are clamped to their legal span
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 16'h0000;
        unique case (s_axi_araddr[7:2])
            vrsr_pkg::IDX_VOLT_KNOB: begin
                rd_val = clamp(voltage_knob_in, vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_STABILITY_KNOB: begin
                rd_val = clamp(stability_adjust_knob_in,
                               vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_FREQ_KNOB: begin
                rd_val = clamp(frequency_knob_in, vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_CURR_KNOB: begin
                rd_val = clamp(current_adjust_knob_in,
                               vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_REG_VOLT: begin
                rd_val = clamp(regulated_voltage_in, vrsr_pkg::VOLT_MAX);
            end
            vrsr_pkg::IDX_FREQ: begin
                rd_val = clamp(frequency_in, vrsr_pkg::FREQ_MAX);
            end
            vrsr_pkg::IDX_ALARMS: begin
                rd_val = active_alarms_in;
            end
            vrsr_pkg::IDX_ACT_CFG: begin
                rd_val = st_q.cfg;
            end
            vrsr_pkg::IDX_COMMAND: begin
                rd_val = 16'h0000;
            end
            vrsr_pkg::IDX_EXT_IN: begin
                rd_val = clamp(external_input_in, vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_NOM_SET: begin
                rd_val = clamp(nominal_setpoint_in, vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_EFF_SET: begin
                rd_val = clamp(effective_setpoint_in,
                               vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_MEAS_VOLT: begin
                rd_val = clamp(measured_voltage_in, vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_TEMP: begin
                rd_val = clamp(winding_temperature_in,
                               vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_VOL_REF: begin
                rd_val = st_q.vol_ref;
            end
            vrsr_pkg::IDX_KP: begin
                rd_val = clamp(proportional_gain_in,
                               vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_KI: begin
                rd_val = clamp(integral_gain_in, vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_OVX_THR: begin
                rd_val = clamp(overexcitation_threshold_in,
                               vrsr_pkg::FULL_MAX);
            end
            vrsr_pkg::IDX_CONFIG: begin
                rd_val = st_q.cfg;
            end
            vrsr_pkg::IDX_NV_REF: begin
                rd_val = st_q.nv_ref;
            end
            vrsr_pkg::IDX_RANGE: begin
                rd_val = {8'h00, st_q.range_pct};
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        st_d = st_q;
        // pin passes two flops before anything reads it
        st_d.open_s1 = ext_link_open;
        st_d.open_s2 = st_q.open_s1;

        if (aw_hs) begin
            st_d.aw_have = 1'b1;
            st_d.aw_idx = s_axi_awaddr[7:2];
        end
        if (w_hs) begin
            st_d.w_have = 1'b1;
            st_d.w_data = s_axi_wdata[15:0];
            st_d.w_strb = s_axi_wstrb[1:0];
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        if ((st_q.aw_have || aw_hs) && (st_q.w_have || w_hs) &&
            !st_q.bvalid) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = vrsr_pkg::RESP_OKAY;
            unique case (wr_idx)
                vrsr_pkg::IDX_COMMAND: begin
                    // accepted and dropped; the host keeps off it
                end
                vrsr_pkg::IDX_VOL_REF: begin
                    st_d.vol_ref = merge(st_q.vol_ref, wr_data,
                                         wr_strb);
                end
                vrsr_pkg::IDX_CONFIG: begin
                    st_d.cfg = merge(st_q.cfg, wr_data, wr_strb);
                end
                vrsr_pkg::IDX_NV_REF: begin
                    st_d.nv_ref = merge(st_q.nv_ref, wr_data, wr_strb);
                end
                vrsr_pkg::IDX_RANGE: begin
                    if (wr_strb[0]) begin
                        st_d.range_pct = 8'(clamp({8'h00, wr_data[7:0]},
                            {8'h00, vrsr_pkg::RANGE_MAX}));
                    end
                end
                default: begin
                    // read-only or unmapped
                    st_d.bresp = vrsr_pkg::RESP_SLVERR;
                end
            endcase
        end

        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = rd_val;
            st_d.rresp = rd_ok ? vrsr_pkg::RESP_OKAY : vrsr_pkg::RESP_SLVERR;
        end

        // reference selection, one cycle behind the configuration
        st_d.saturated = 1'b0;
        st_d.variation = 8'h00;
        if (ext_en) begin
            if (!ref_src) begin
                st_d.mode = vrsr_pkg::MODE_ANALOG;
                st_d.vref_out = clamp(external_input_in,
                                      vrsr_pkg::FULL_MAX);
            end else begin
                st_d.mode = vrsr_pkg::MODE_ANALOG_SAT;
                if (st_q.open_s2) begin
                    // open wire must not read as a low setpoint
                    st_d.vref_out = vrsr_pkg::FULL_MAX;
                    st_d.variation = st_q.range_pct;
                    st_d.saturated = 1'b1;
                end else if (external_input_in >= vrsr_pkg::EXT_LIMIT) begin
                    st_d.vref_out = vrsr_pkg::EXT_LIMIT;
                    st_d.saturated = 1'b1;
                end else begin
                    st_d.vref_out = external_input_in;
                end
            end
        end else if (!ref_src) begin
            st_d.mode = vrsr_pkg::MODE_NV_PARAM;
            st_d.vref_out = st_q.nv_ref;
            // overrides any host write of the same cycle
            st_d.vol_ref = st_q.nv_ref;
        end else begin
            st_d.mode = vrsr_pkg::MODE_RAM_LOC;
            st_d.vref_out = st_q.vol_ref;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.cfg <= vrsr_pkg::CFG_RESET;
            st_q.nv_ref <= vrsr_pkg::NV_REF_RESET;
            st_q.range_pct <= vrsr_pkg::RANGE_RESET;
            // volatile value never survives a restart
            st_q.vol_ref <= vrsr_pkg::VOL_REF_RESET;
            st_q.mode <= vrsr_pkg::MODE_ANALOG;
        end else begin
            st_q <= st_d;
        end
    end

    property p_nv_align;
        @(posedge aclk) disable iff (!aresetn)
        (!ext_en && !ref_src) |=> (st_q.vol_ref == $past(st_q.nv_ref));
    endproperty
    a_nv_align: assert property (p_nv_align)
        else $error("volatile ref not aligned to stored ref");

    property p_nv_ref;
        @(posedge aclk) disable iff (!aresetn)
        (!ext_en && !ref_src) |=> (voltage_reference == $past(st_q.nv_ref));
    endproperty
    a_nv_ref: assert property (p_nv_ref)
        else $error("stored mode reference wrong");

    property p_nv_ignore;
        @(posedge aclk) disable iff (!aresetn)
        (!ext_en && !ref_src && st_d.bvalid && !st_q.bvalid &&
         wr_idx == vrsr_pkg::IDX_VOL_REF) |=>
            (st_q.vol_ref == $past(st_q.nv_ref));
    endproperty
    a_nv_ignore: assert property (p_nv_ignore)
        else $error("volatile write leaked into stored mode");

    property p_ram_ref;
        @(posedge aclk) disable iff (!aresetn)
        (!ext_en && ref_src) |=> (voltage_reference == $past(st_q.vol_ref))
            && (reference_mode == vrsr_pkg::MODE_RAM_LOC);
    endproperty
    a_ram_ref: assert property (p_ram_ref)
        else $error("ram mode reference wrong");

    property p_sat;
        @(posedge aclk) disable iff (!aresetn)
        (ext_en && ref_src && !st_q.open_s2 &&
         external_input_in >= vrsr_pkg::EXT_LIMIT) |=>
            output_saturated && voltage_reference == vrsr_pkg::EXT_LIMIT;
    endproperty
    a_sat: assert property (p_sat)
        else $error("saturation missing at input limit");

    property p_nosat;
        @(posedge aclk) disable iff (!aresetn)
        (ext_en && !ref_src) |=> !output_saturated;
    endproperty
    a_nosat: assert property (p_nosat)
        else $error("saturation without bit 7");

    property p_open;
        @(posedge aclk) disable iff (!aresetn)
        (ext_en && ref_src && st_q.open_s2) |=>
            (remote_variation_pct == $past(st_q.range_pct)) &&
            (voltage_reference == vrsr_pkg::FULL_MAX);
    endproperty
    a_open: assert property (p_open)
        else $error("open link not driven to range limit");

    property p_rd_volt;
        @(posedge aclk) disable iff (!aresetn)
        (ar_hs && s_axi_araddr[7:2] == vrsr_pkg::IDX_REG_VOLT) |=>
            s_axi_rvalid && s_axi_rdata <= 32'(vrsr_pkg::VOLT_MAX);
    endproperty
    a_rd_volt: assert property (p_rd_volt)
        else $error("regulated voltage out of range");

    property p_rd_freq;
        @(posedge aclk) disable iff (!aresetn)
        (ar_hs && s_axi_araddr[7:2] == vrsr_pkg::IDX_FREQ) |=>
            s_axi_rvalid && s_axi_rdata <= 32'(vrsr_pkg::FREQ_MAX);
    endproperty
    a_rd_freq: assert property (p_rd_freq)
        else $error("frequency out of range");

endmodule

`default_nettype wire

// ==== dv/vrsr_core_model.sv ====
/*
 * vrsr_core_model: stand-in for the regulator core and the analogue link
 * that feed the register bank.
 * assumes: the bench picks the external input level and the link state.
 */
`timescale 1ns/1ps
`default_nettype none
module vrsr_core_model (
    input wire logic aclk,
    input wire logic ext_high,
    input wire logic link_open_req,
    output logic [15:0] voltage_knob_in,
    output logic [15:0] stability_adjust_knob_in,
    output logic [15:0] frequency_knob_in,
    output logic [15:0] current_adjust_knob_in,
    output logic [15:0] regulated_voltage_in,
    output logic [15:0] frequency_in,
    output logic [15:0] active_alarms_in,
    output logic [15:0] external_input_in,
    output logic [15:0] nominal_setpoint_in,
    output logic [15:0] effective_setpoint_in,
    output logic [15:0] measured_voltage_in,
    output logic [15:0] winding_temperature_in,
    output logic [15:0] proportional_gain_in,
    output logic [15:0] integral_gain_in,
    output logic [15:0] overexcitation_threshold_in,
    output logic ext_link_open
);
    // some values sit above their range so clamping becomes visible
    assign voltage_knob_in = 16'h1234;
    assign stability_adjust_knob_in = 16'h8001;
    assign frequency_knob_in = 16'h0100;
    assign current_adjust_knob_in = 16'h7fff;
    assign regulated_voltage_in = 16'h0d00;
    assign frequency_in = 16'h0384;
    assign active_alarms_in = 16'ha5a5;
    assign external_input_in = ext_high ? 16'hffff : 16'h1000;
    assign nominal_setpoint_in = 16'h2000;
    assign effective_setpoint_in = 16'h1f00;
    assign measured_voltage_in = 16'h0c00;
    assign winding_temperature_in = 16'h0050;
    assign proportional_gain_in = 16'h0123;
    assign integral_gain_in = 16'h0456;
    assign overexcitation_threshold_in = 16'hffff;
    // pin moves on the falling edge: it is asynchronous to the bank
    initial begin
        ext_link_open = 1'b0;
        forever @(negedge aclk) ext_link_open <= link_open_req;
    end
endmodule
`default_nettype wire

// ==== dv/tb_voltage_reference_select_regs.sv ====
/*
 * tb_voltage_reference_select_regs: register and reference-mode tests
 * driven through AXI4-Lite read and write tasks.
 * assumes: core model supplies fixed measurements and the link pin.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_voltage_reference_select_regs;
    localparam logic [1:0] OK = vrsr_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = vrsr_pkg::RESP_SLVERR;
    localparam logic [7:0] A_CFG = {vrsr_pkg::IDX_CONFIG, 2'b00};
    localparam logic [7:0] A_NV = {vrsr_pkg::IDX_NV_REF, 2'b00};
    localparam logic [7:0] A_RNG = {vrsr_pkg::IDX_RANGE, 2'b00};
    localparam logic [7:0] A_VREF = {vrsr_pkg::IDX_VOL_REF, 2'b00};
    localparam logic [7:0] A_KP = {vrsr_pkg::IDX_KP, 2'b00};
    logic aclk, aresetn, ext_high, link_open_req;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] voltage_knob_in, stability_adjust_knob_in;
    logic [15:0] frequency_knob_in, current_adjust_knob_in;
    logic [15:0] regulated_voltage_in, frequency_in, active_alarms_in;
    logic [15:0] external_input_in, nominal_setpoint_in;
    logic [15:0] effective_setpoint_in, measured_voltage_in;
    logic [15:0] winding_temperature_in, proportional_gain_in;
    logic [15:0] integral_gain_in, overexcitation_threshold_in;
    logic ext_link_open, output_saturated;
    logic [15:0] voltage_reference;
    logic [7:0] remote_variation_pct;
    vrsr_pkg::vrsr_mode_t reference_mode;
    int bad_count;
    int compares;
    logic [5:0] ro_idx [16];
    logic [15:0] ro_exp [16];

    vrsr_top uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .voltage_knob_in, .stability_adjust_knob_in,
        .frequency_knob_in, .current_adjust_knob_in, .regulated_voltage_in,
        .frequency_in, .active_alarms_in, .external_input_in,
        .nominal_setpoint_in, .effective_setpoint_in, .measured_voltage_in,
        .winding_temperature_in, .proportional_gain_in, .integral_gain_in,
        .overexcitation_threshold_in, .ext_link_open, .voltage_reference,
        .remote_variation_pct, .output_saturated, .reference_mode
    );

    vrsr_core_model core (
        .aclk, .ext_high, .link_open_req, .voltage_knob_in,
        .stability_adjust_knob_in, .frequency_knob_in,
        .current_adjust_knob_in, .regulated_voltage_in, .frequency_in,
        .active_alarms_in, .external_input_in, .nominal_setpoint_in,
        .effective_setpoint_in, .measured_voltage_in,
        .winding_temperature_in, .proportional_gain_in, .integral_gain_in,
        .overexcitation_threshold_in, .ext_link_open
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic tally_and_finish;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic hang;
        bad_count++;
        $display("ERROR t=%0t no answer from the bank", $time);
        tally_and_finish();
    endtask

    // holds each channel until its own handshake, bready until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        bit got;
        got = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                got = 1'b1;
                check({30'h0, s_axi_bresp}, {30'h0, er});
                s_axi_bready <= 1'b0;
            end
        end
        if (!got) hang();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        bit got;
        got = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                got = 1'b1;
                check(s_axi_rdata, ed);
                check({30'h0, s_axi_rresp}, {30'h0, er});
                s_axi_rready <= 1'b0;
            end
        end
        if (!got) hang();
    endtask

    task automatic rst;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // reference outputs follow a register change one edge later
    task automatic outs(input vrsr_pkg::vrsr_mode_t m, input logic [15:0] v,
                        input logic sat, input logic [7:0] pct);
        repeat (2) @(posedge aclk);
        check({30'h0, reference_mode}, {30'h0, m});
        check({16'h0, voltage_reference}, {16'h0, v});
        check({31'h0, output_saturated}, {31'h0, sat});
        check({24'h0, remote_variation_pct}, {24'h0, pct});
    endtask

    initial begin
        aresetn = 1'b0;
        ext_high = 1'b0;
        link_open_req = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        bad_count = 0;
        compares = 0;
        ro_idx = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27,
                   6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h35, 6'h36, 6'h37};
        ro_exp = '{16'h1234, 16'h7fff, 16'h0100, 16'h7fff, 16'h0c80,
                   16'h0384, 16'ha5a5, vrsr_pkg::CFG_RESET, 16'h1000,
                   16'h2000, 16'h1f00, 16'h0c00, 16'h0050, 16'h0123,
                   16'h0456, 16'h7fff};
        rst();
        rd(A_CFG, {16'h0, vrsr_pkg::CFG_RESET}, OK);
        rd(A_RNG, {24'h0, vrsr_pkg::RANGE_RESET}, OK);
        for (int i = 0; i < 16; i++) begin
            rd({ro_idx[i], 2'b00}, {16'h0, ro_exp[i]}, OK);
        end // also
        wr(A_KP, 32'h1, 4'hf, ERR);
        rd(A_KP, 32'h0123, OK);
        wr({6'h24, 2'b00}, 32'h1, 4'hf, ERR);
        rd(8'hc0, 32'h0, ERR);
        wr(8'hc0, 32'h1, 4'hf, ERR);
        // the command word is never written from here
        rd({vrsr_pkg::IDX_COMMAND, 2'b00}, 32'h0, OK);
        outs(vrsr_pkg::MODE_ANALOG, 16'h1000, 1'b0, 8'h00);
        ext_high <= 1'b1;
        outs(vrsr_pkg::MODE_ANALOG, 16'h7fff, 1'b0, 8'h00);
        wr(A_CFG, 32'h1f9d, 4'h3, OK);
        outs(vrsr_pkg::MODE_ANALOG_SAT, 16'h7fff, 1'b1, 8'h00);
        rd({6'h27, 2'b00}, 32'h1f9d, OK);
        ext_high <= 1'b0;
        wr(A_RNG, 32'hc8, 4'h1, OK);
        rd(A_RNG, {24'h0, vrsr_pkg::RANGE_MAX}, OK);
        wr(A_RNG, 32'h14, 4'h1, OK);
        outs(vrsr_pkg::MODE_ANALOG_SAT, 16'h1000, 1'b0, 8'h00);
        link_open_req <= 1'b1;
        repeat (3) @(posedge aclk);
        outs(vrsr_pkg::MODE_ANALOG_SAT, 16'h7fff, 1'b1, 8'h14);
        link_open_req <= 1'b0;
        repeat (3) @(posedge aclk);
        outs(vrsr_pkg::MODE_ANALOG_SAT, 16'h1000, 1'b0, 8'h00);
        wr(A_NV, 32'h2345, 4'h3, OK);
        wr(A_CFG, 32'h0f1d, 4'h3, OK);
        outs(vrsr_pkg::MODE_NV_PARAM, 16'h2345, 1'b0, 8'h00);
        rd(A_VREF, 32'h2345, OK);
        wr(A_VREF, 32'h1111, 4'h3, OK);
        rd(A_VREF, 32'h2345, OK);
        outs(vrsr_pkg::MODE_NV_PARAM, 16'h2345, 1'b0, 8'h00);
        wr(A_CFG, 32'h0f9d, 4'h3, OK);
        wr(A_VREF, 32'h0abc, 4'h3, OK);
        outs(vrsr_pkg::MODE_RAM_LOC, 16'h0abc, 1'b0, 8'h00);
        // lane 1 only, upper half ignored
        wr(A_VREF, 32'hffff5566, 4'h2, OK);
        rd(A_VREF, 32'h55bc, OK);
        wr(A_NV, 32'h0777, 4'h3, OK);
        outs(vrsr_pkg::MODE_RAM_LOC, 16'h55bc, 1'b0, 8'h00);
        rst();
        rd(A_VREF, {16'h0, vrsr_pkg::VOL_REF_RESET}, OK);
        rd(A_CFG, {16'h0, vrsr_pkg::CFG_RESET}, OK);
        tally_and_finish();
    end
endmodule
`default_nettype wire
